// ==== hdl/input_delay_tap_control.sv ====
// tap control for a programmable input delay line
// What this block does
// - tap count output shows taps currently selected
// - element reset is synchronous and returns taps to initial setting
// - comp_enable high lets calibration hold delay in time format only; low disables it
// - output carries selected source delayed; fabric data never reaches pad chain
// - source select picks pad or fabric input, pad by default
// - delay type fixed, variable or variable-with-load, fixed by default
// - count format initial setting is 0 to 511 taps, default 0
// - time format initial setting in ps, limited 1250 or 1100, plus align
// - reference frequency 200.0 to 800.0 MHz, default 300.0
// - update mode async, sync or manual, async by default
// - cascade role none, master, middle or end; none when unchained
// - chaining runs downward only; chained element serves chain only
// - load, step enable and direction are sampled on the clock
// - step enable moves one tap per clock by direction in async mode, only on data edges in sync, never in manual; else no change
// - tap counter wraps at both ends
// - load takes tap_count_in in variable-with-load type, initial taps in variable type; value set a clock early, step low
`timescale 1ns/1ps
module input_delay_tap_control
    import tap_ctrl_pkg::*;
#(
    parameter logic [11:0] TAP_PS     = 12'h005,  // ps per tap in time format
    parameter logic [11:0] ALIGN_TAPS = 12'h037   // alignment offset in taps
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    // tap control from fabric
    input  wire logic        dly_reset_i,
    input  wire logic        load_i,
    input  wire logic        step_en_i,
    input  wire logic        step_dir_i,
    input  wire logic [8:0]  tap_count_in_i,
    input  wire logic        comp_enable_i,
    input  wire logic        calib_ready_i,
    output logic [8:0]       tap_count_out_o,
    output logic             comp_active_o,
    // data path
    input  wire logic        pad_in_i,
    input  wire logic        fabric_in_i,
    input  wire logic        chain_in_i,
    output logic             delayed_out_o,
    output logic             chain_out_o
);
    typedef struct packed {
        logic [CFG_WIDTH-1:0] cfg;
        logic [10:0]          init;
        logic [13:0]          ref_freq;
        logic                 refused;
        logic                 staged_valid;
        logic [8:0]           staged;
        logic [8:0]           tap;
        logic                 comp_active;
        logic [2:0]           pad_sync;
        logic                 pad_level;
        logic                 src_prev;
        logic                 chain;
        logic [31:0]          rdata;
    } ctrl_s;

    ctrl_s st;
    ctrl_s next_st;

    logic       src_fabric;
    logic [1:0] dly_type;
    logic       fmt_count;
    logic [1:0] upd_mode;
    logic [1:0] casc;
    logic [10:0] max_ps;
    logic [10:0] ps_clamped;
    logic [11:0] time_taps;
    logic [8:0] init_taps;
    logic       src_data;
    logic       data_edge;
    logic       update_req;
    logic       step_go;
    logic       line_out;

    // configuration fields
    assign src_fabric = st.cfg[SRC_BIT];
    assign dly_type   = st.cfg[TYPE_LSB +: 2];
    assign fmt_count  = st.cfg[FORMAT_BIT];
    assign upd_mode   = st.cfg[UPD_LSB +: 2];
    assign casc       = st.cfg[CASC_LSB +: 2];

    // initial tap setting from the initial delay value
    always_comb begin
        max_ps     = st.cfg[TARGET_BIT] ? MAX_PS_LATER : MAX_PS_FIRST;
        ps_clamped = (st.init > max_ps) ? max_ps : st.init;
        time_taps  = 12'({1'b0, ps_clamped} / TAP_PS) + ALIGN_TAPS;
        if (fmt_count) begin
            init_taps = (st.init > MAX_COUNT) ? 9'h1FF : st.init[8:0];
        end else if (time_taps > 12'h1FF) begin
            init_taps = 9'h1FF;
        end else begin
            init_taps = time_taps[8:0];
        end
    end

    // source selection; slaves take the neighbour's chain
    always_comb begin
        if (casc == CASC_CHAIN_MIDDLE || casc == CASC_END) begin
            src_data = chain_in_i;
        end else if (src_fabric) begin
            src_data = fabric_in_i;
        end else begin
            src_data = st.pad_level;
        end
    end

    // sync update mode only steps taps on a data transition; loads are not gated
    assign data_edge  = src_data != st.src_prev;
    assign update_req = load_i | step_en_i;
    assign step_go    = step_en_i && !load_i && !comp_enable_i && dly_type != TYPE_FIXED
                        && (upd_mode == UPD_ASYNC || (upd_mode == UPD_SYNC && data_edge));

    // next state of the whole block
    always_comb begin
        next_st = st;
        // three-stage pad synchroniser, level taken once stages two and three agree
        next_st.pad_sync = {st.pad_sync[1:0], pad_in_i};
        if (st.pad_sync[1] == st.pad_sync[2]) begin
            next_st.pad_level = st.pad_sync[2];
        end
        next_st.src_prev = src_data;
        next_st.comp_active = comp_enable_i && !fmt_count && calib_ready_i;
        next_st.chain = (casc != CASC_NONE && casc != CASC_END && !src_fabric) ? line_out : 1'b0;

        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                CFG_OFFSET: begin
                    next_st.cfg = reg_wdata_i[CFG_WIDTH-1:0];
                end
                INIT_OFFSET: begin
                    next_st.init = reg_wdata_i[10:0];
                end
                REF_OFFSET: begin
                    if (reg_wdata_i[13:0] >= REF_MIN && reg_wdata_i[13:0] <= REF_MAX
                        && reg_wdata_i[31:14] == 18'h00000) begin
                        next_st.ref_freq = reg_wdata_i[13:0];
                    end
                end
                STATUS_OFFSET: begin
                    if (reg_wdata_i[ST_REF_BIT]) begin
                        next_st.refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads, data stand in the following cycle
        next_st.rdata = 32'h00000000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                CFG_OFFSET:    next_st.rdata = 32'(st.cfg);
                INIT_OFFSET:   next_st.rdata = 32'(st.init);
                REF_OFFSET:    next_st.rdata = 32'(st.ref_freq);
                STATUS_OFFSET: next_st.rdata = 32'({st.staged_valid, st.refused, st.comp_active, st.tap});
                default:       next_st.rdata = 32'h00000000;
            endcase
        end

        // tap setting; element reset wins, fixed ignores controls
        if (dly_reset_i) begin
            next_st.tap = init_taps;
            next_st.staged_valid = 1'b0;
        end else if (dly_type == TYPE_FIXED) begin
            next_st.tap = init_taps;
        end else if (comp_enable_i) begin
            if (update_req) begin
                next_st.refused = 1'b1;
            end
        end else if (load_i) begin
            if (upd_mode == UPD_MANUAL) begin
                if (step_en_i && st.staged_valid) begin
                    next_st.tap = st.staged;
                    next_st.staged_valid = 1'b0;
                end else if (!step_en_i) begin
                    next_st.staged = (dly_type == TYPE_VAR_LOAD) ? tap_count_in_i : init_taps;
                    next_st.staged_valid = 1'b1;
                end else begin
                    next_st.refused = 1'b1;
                end
            end else if (step_en_i) begin
                next_st.refused = 1'b1;
            end else if (dly_type == TYPE_VAR_LOAD) begin
                next_st.tap = tap_count_in_i;
            end else begin
                next_st.tap = init_taps;
            end
        end else if (step_go) begin
            next_st.tap = step_dir_i ? 9'(st.tap + 1'b1) : 9'(st.tap - 1'b1);
        end
    end

    // all state on the single control clock
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st          <= '0;
            st.cfg      <= CFG_RESET;
            st.init     <= INIT_RESET;
            st.ref_freq <= REF_RESET;
            st.tap      <= TAP_RESET;
        end else begin
            st <= next_st;
        end
    end

    // delay line memory
    tap_line_mem #(
        .DEPTH (512),
        .AW    (9)
    ) u_line (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .data_i    (src_data),
        .tap_i     (st.tap),
        .data_o    (line_out)
    );

    // outputs
    assign tap_count_out_o = st.tap;
    assign comp_active_o   = st.comp_active;
    assign delayed_out_o   = line_out;
    assign chain_out_o     = st.chain;
    assign reg_rdata_o     = st.rdata;

    // checks
    a_tap_stable: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (!reset_i && !dly_reset_i && !load_i && !step_en_i && dly_type != TYPE_FIXED && !reg_wr_i)
        |=> $stable(tap_count_out_o))
        else $error("tap count changed without an update");
    a_reset_init: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        dly_reset_i && !reg_wr_i |=> tap_count_out_o == $past(init_taps))
        else $error("element reset did not restore initial taps");
    a_count_init: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        dly_reset_i && fmt_count && st.init <= MAX_COUNT && !reg_wr_i
        |=> tap_count_out_o == $past(st.init[8:0]))
        else $error("count format initial taps wrong");
    a_comp_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ##1 comp_active_o == $past(comp_enable_i && !fmt_count && calib_ready_i))
        else $error("compensation state wrong");
    a_step_move: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        step_go && !dly_reset_i && !reg_wr_i
        |=> tap_count_out_o == ($past(step_dir_i) ? 9'($past(st.tap) + 1'b1) : 9'($past(st.tap) - 1'b1)))
        else $error("step did not move one tap");
    a_wrap_top: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        step_go && step_dir_i && st.tap == 9'h1FF && !dly_reset_i && !reg_wr_i |=> tap_count_out_o == 9'h000)
        else $error("increment from last tap did not wrap");
    a_load_value: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        load_i && !step_en_i && !comp_enable_i && !dly_reset_i && dly_type == TYPE_VAR_LOAD
        && upd_mode != UPD_MANUAL && !reg_wr_i |=> tap_count_out_o == $past(tap_count_in_i))
        else $error("load did not take the input value");
    a_fixed_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !reset_i && dly_type == TYPE_FIXED && !reg_wr_i |=> tap_count_out_o == $past(init_taps))
        else $error("fixed operation reacted to controls");
    a_wrap_bottom: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        step_go && !step_dir_i && st.tap == 9'h000 && !dly_reset_i && !reg_wr_i |=> tap_count_out_o == 9'h1FF)
        else $error("decrement from tap zero did not wrap");
    a_refuse_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !reset_i && comp_enable_i && (load_i || step_en_i) && !dly_reset_i && dly_type != TYPE_FIXED
        |=> st.refused)
        else $error("update under compensation not flagged");
    a_manual_apply: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        load_i && step_en_i && st.staged_valid && upd_mode == UPD_MANUAL && !comp_enable_i && !dly_reset_i
        && dly_type != TYPE_FIXED && !reg_wr_i |=> tap_count_out_o == $past(st.staged))
        else $error("manual apply did not take the staged taps");
    a_chain_copy: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !reset_i && casc == CASC_MASTER && !src_fabric && !reg_wr_i |=> chain_out_o == $past(delayed_out_o))
        else $error("master did not pass the line on");
    a_defaults: assert property (@(posedge sys_clk_i)
        reset_i |=> st.cfg == CFG_RESET && st.ref_freq == REF_RESET)
        else $error("defaults wrong after reset");
    a_ref_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        st.ref_freq >= REF_MIN && st.ref_freq <= REF_MAX)
        else $error("reference frequency out of range");
    a_chain_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (casc == CASC_NONE || src_fabric) && !reg_wr_i |=> !chain_out_o)
        else $error("chain output driven while unchained or fabric sourced");

    c_step: cover property (@(posedge sys_clk_i) disable iff (reset_i) step_go ##1 step_go);
    c_load: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        load_i && dly_type == TYPE_VAR_LOAD && upd_mode == UPD_ASYNC);
    c_manual: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        load_i && step_en_i && st.staged_valid && upd_mode == UPD_MANUAL);
    c_wrap: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        step_go && !step_dir_i && st.tap == 9'h000);
    c_chain: cover property (@(posedge sys_clk_i) disable iff (reset_i) casc == CASC_MASTER && chain_out_o);
endmodule // input_delay_tap_control

// ==== hdl/tap_ctrl_pkg.sv ====
// shared constants for the input delay tap control block
package tap_ctrl_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] CFG_OFFSET    = 4'h0;
    localparam logic [3:0] INIT_OFFSET   = 4'h4;
    localparam logic [3:0] REF_OFFSET    = 4'h8;
    localparam logic [3:0] STATUS_OFFSET = 4'hC;

    // configuration field positions
    localparam int SRC_BIT     = 0;   // 0 pad, 1 fabric
    localparam int TYPE_LSB    = 1;   // two bits, delay type
    localparam int FORMAT_BIT  = 3;   // 0 time, 1 count
    localparam int UPD_LSB     = 4;   // two bits, update mode
    localparam int CASC_LSB    = 6;   // two bits, cascade role
    localparam int TARGET_BIT  = 8;   // 0 first generation, 1 later one
    localparam int CFG_WIDTH   = 9;

    // status field positions
    localparam int ST_TAP_LSB  = 0;   // nine bits of tap count
    localparam int ST_COMP_BIT = 9;
    localparam int ST_REF_BIT  = 10;  // sticky: refused update
    localparam int ST_STG_BIT  = 11;  // manual value staged

    // delay type codes
    localparam logic [1:0] TYPE_FIXED    = 2'h0;
    localparam logic [1:0] TYPE_VARIABLE = 2'h1;
    localparam logic [1:0] TYPE_VAR_LOAD = 2'h2;

    // update mode codes
    localparam logic [1:0] UPD_ASYNC  = 2'h0;
    localparam logic [1:0] UPD_SYNC   = 2'h1;
    localparam logic [1:0] UPD_MANUAL = 2'h2;

    // cascade role codes
    localparam logic [1:0] CASC_NONE         = 2'h0;
    localparam logic [1:0] CASC_MASTER       = 2'h1;
    localparam logic [1:0] CASC_CHAIN_MIDDLE = 2'h2;
    localparam logic [1:0] CASC_END          = 2'h3;

    // values after reset
    localparam logic [CFG_WIDTH-1:0] CFG_RESET  = 9'h000;
    localparam logic [10:0]          INIT_RESET = 11'h000;
    localparam logic [13:0]          REF_RESET  = 14'h0BB8;  // 300.0 MHz in tenths
    localparam logic [8:0]           TAP_RESET  = 9'h000;

    // limits of the settings
    localparam logic [10:0] MAX_PS_FIRST = 11'h4E2;   // 1250 ps
    localparam logic [10:0] MAX_PS_LATER = 11'h44C;   // 1100 ps
    localparam logic [10:0] MAX_COUNT    = 11'h1FF;   // 511 taps
    localparam logic [13:0] REF_MIN      = 14'h07D0;  // 200.0 MHz
    localparam logic [13:0] REF_MAX      = 14'h1F40;  // 800.0 MHz
endpackage

// ==== hdl/tap_line_mem.sv ====
// circular bit memory that forms the tapped delay line
`timescale 1ns/1ps
module tap_line_mem #(
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    // clock and reset
    input  wire logic          sys_clk_i,
    input  wire logic          reset_i,
    // sample in, tap select, delayed sample out
    input  wire logic          data_i,
    input  wire logic [AW-1:0] tap_i,
    output logic               data_o
);
    typedef struct packed {
        logic [DEPTH-1:0] bits;
        logic [AW-1:0]    wptr;
        logic             rdata;
    } mem_s;

    mem_s st;
    mem_s next_st;

    // write every cycle, read the sample tap_i positions back
    // tap zero takes the fresh sample: the slot under wptr holds the oldest one
    always_comb begin
        next_st = st;
        next_st.bits[st.wptr] = data_i;
        next_st.wptr = AW'(st.wptr + 1'b1);
        if (tap_i == '0) begin
            next_st.rdata = data_i;
        end else begin
            next_st.rdata = st.bits[AW'(st.wptr - tap_i)];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign data_o = st.rdata;
endmodule // tap_line_mem

// ==== sim/fabric_tap_driver.sv ====
// fabric-side model that drives the tap control inputs of the delay block
`timescale 1ns/1ps
module fabric_tap_driver (
    // clock
    input  wire logic  sys_clk_i,
    // tap control toward the block
    output logic       dly_reset_o,
    output logic       load_o,
    output logic       step_en_o,
    output logic       step_dir_o,
    output logic [8:0] tap_value_o,
    output logic       comp_enable_o,
    output logic       calib_ready_o
);
    // calibration side reports ready a few cycles after start
    initial begin
        {dly_reset_o, load_o, step_en_o, step_dir_o, comp_enable_o, calib_ready_o} = 6'h00;
        tap_value_o = 9'h000;
        repeat (6) @(posedge sys_clk_i);
        calib_ready_o <= 1'b1;
    end
    // value stands one clock before the load pulse, step held low
    task automatic load(input logic [8:0] v);
        @(posedge sys_clk_i);
        comp_enable_o <= 1'b0;
        tap_value_o   <= v;
        @(posedge sys_clk_i);
        load_o <= 1'b1;
        @(posedge sys_clk_i);
        load_o <= 1'b0;
    endtask
    // n back-to-back steps; comp stays high only when a refusal is wanted
    task automatic step(input logic dir, input int n, input logic comp);
        @(posedge sys_clk_i);
        comp_enable_o <= comp;
        step_dir_o    <= dir;
        step_en_o     <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        step_en_o     <= 1'b0;
        comp_enable_o <= 1'b0;
    endtask
    // manual mode: second load with step high makes the staged value live
    task automatic apply();
        @(posedge sys_clk_i);
        comp_enable_o <= 1'b0;
        load_o        <= 1'b1;
        step_en_o     <= 1'b1;
        @(posedge sys_clk_i);
        load_o        <= 1'b0;
        step_en_o     <= 1'b0;
    endtask
    // element reset only once calibration is ready
    task automatic pulse_reset();
        while (calib_ready_o !== 1'b1) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        dly_reset_o <= 1'b1;
        @(posedge sys_clk_i);
        dly_reset_o <= 1'b0;
    endtask
endmodule // fabric_tap_driver

// ==== sim/tb.sv ====
// self-checking bench for the input delay tap control block
`timescale 1ns/1ps
module tb;
    import tap_ctrl_pkg::*;
    localparam logic [11:0] TAP_PS = 12'h005;
    localparam logic [11:0] ALIGN  = 12'h037;
    localparam logic [31:0] T_TAPS = 32'(12'h064 / TAP_PS + ALIGN);
    localparam logic [31:0] T_LATER = 32'(12'(MAX_PS_LATER) / TAP_PS + ALIGN);
    localparam logic [2:0]  K_WR = 3'h0, K_RD = 3'h1, K_LD = 3'h2, K_UP = 3'h3;
    localparam logic [2:0]  K_DN = 3'h4, K_RST = 3'h5, K_TAP = 3'h6;
    typedef struct packed {logic [2:0] kind; logic [3:0] addr; logic [31:0] data; logic [31:0] exp;} row_s;
    // each row: operation, address, data or step count, expected read or tap
    row_s rows [27] = '{
        '{K_RD, CFG_OFFSET, 32'h0, 32'h0}, '{K_RD, INIT_OFFSET, 32'h0, 32'h0},
        '{K_RD, REF_OFFSET, 32'h0, 32'h0BB8}, '{K_RD, 4'h2, 32'h0, 32'h0},
        '{K_WR, REF_OFFSET, 32'h07CF, 32'h0}, '{K_RD, REF_OFFSET, 32'h0, 32'h0BB8},
        '{K_WR, REF_OFFSET, 32'h1F40, 32'h0}, '{K_RD, REF_OFFSET, 32'h0, 32'h1F40},
        '{K_WR, INIT_OFFSET, 32'h064, 32'h0}, '{K_TAP, 4'h0, 32'h0, T_TAPS},
        '{K_LD, 4'h0, 32'h005, T_TAPS}, '{K_UP, 4'h0, 32'h2, T_TAPS},
        '{K_WR, CFG_OFFSET, 32'h100, 32'h0}, '{K_WR, INIT_OFFSET, 32'h4E2, 32'h0},
        '{K_TAP, 4'h0, 32'h0, T_LATER}, '{K_WR, INIT_OFFSET, 32'h064, 32'h0},
        '{K_WR, CFG_OFFSET, 32'h00C, 32'h0}, '{K_LD, 4'h0, 32'h005, 32'h005},
        '{K_UP, 4'h0, 32'h3, 32'h008}, '{K_DN, 4'h0, 32'h1, 32'h007},
        '{K_LD, 4'h0, 32'h1FF, 32'h1FF}, '{K_UP, 4'h0, 32'h1, 32'h000},
        '{K_DN, 4'h0, 32'h1, 32'h1FF}, '{K_RST, 4'h0, 32'h0, 32'h064},
        '{K_RD, STATUS_OFFSET, 32'h0, 32'h064}, '{K_WR, INIT_OFFSET, 32'h3FF, 32'h0},
        '{K_RST, 4'h0, 32'h0, 32'h1FF}};
    logic        sys_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        pad_in    = 1'b0;
    logic        fabric_in = 1'b0;
    logic        chain_in  = 1'b0;
    logic        chain_out;
    logic [31:0] reg_rdata, rd;
    logic [8:0]  tap_value, tap_out;
    logic        dly_reset, load, step_en, step_dir, comp_en, calib_rdy, comp_act, delayed_out;
    int          fail_count = 0;
    int          compares   = 0;
    int          cycles     = 0;

    input_delay_tap_control #(.TAP_PS(TAP_PS), .ALIGN_TAPS(ALIGN)) input_delay_tap_control_inst (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .dly_reset_i(dly_reset),
        .load_i(load), .step_en_i(step_en), .step_dir_i(step_dir), .tap_count_in_i(tap_value),
        .comp_enable_i(comp_en), .calib_ready_i(calib_rdy), .tap_count_out_o(tap_out),
        .comp_active_o(comp_act), .pad_in_i(pad_in), .fabric_in_i(fabric_in), .chain_in_i(chain_in),
        .delayed_out_o(delayed_out), .chain_out_o(chain_out));
    fabric_tap_driver fabric_tap_driver_inst (
        .sys_clk_i(sys_clk_i), .dly_reset_o(dly_reset), .load_o(load), .step_en_o(step_en),
        .step_dir_o(step_dir), .tap_value_o(tap_value), .comp_enable_o(comp_en),
        .calib_ready_o(calib_rdy));

    // clock and hang guard
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd   <= 1'b0;
        @(negedge sys_clk_i);
        d = reg_rdata;
    endtask
    task automatic stop_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence: table rows, then hand-written cases
    initial begin
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        foreach (rows[i]) begin
            case (rows[i].kind)
                K_WR: reg_write(rows[i].addr, rows[i].data);
                K_RD: begin
                    reg_read(rows[i].addr, rd);
                    check(rd, rows[i].exp);
                end
                K_LD: fabric_tap_driver_inst.load(rows[i].data[8:0]);
                K_UP: fabric_tap_driver_inst.step(1'b1, int'(rows[i].data), 1'b0);
                K_DN: fabric_tap_driver_inst.step(1'b0, int'(rows[i].data), 1'b0);
                K_RST: fabric_tap_driver_inst.pulse_reset();
                default: repeat (3) @(posedge sys_clk_i);
            endcase
            if (rows[i].kind > K_RD) begin
                @(negedge sys_clk_i);
                check({23'h0, tap_out}, rows[i].exp);
            end
        end
        // update with comp_enable high is refused and flagged
        fabric_tap_driver_inst.step(1'b1, 1, 1'b1);
        @(negedge sys_clk_i);
        check({23'h0, tap_out}, 32'h1FF);
        reg_read(STATUS_OFFSET, rd);
        check(rd, 32'h5FF);
        reg_write(STATUS_OFFSET, 32'h400);
        reg_read(STATUS_OFFSET, rd);
        check(rd, 32'h1FF);
        // compensation active only in time format with calibration ready
        reg_write(CFG_OFFSET, 32'h004);
        fabric_tap_driver_inst.step(1'b0, 3, 1'b1);
        @(negedge sys_clk_i);
        check({31'h0, comp_act}, 32'h1);
        check({23'h0, tap_out}, 32'h1FF);
        // fabric source then pad source through tap zero
        reg_write(CFG_OFFSET, 32'h00D);
        fabric_tap_driver_inst.load(9'h000);
        fabric_in <= 1'b1;
        repeat (8) @(negedge sys_clk_i);
        check({31'h0, delayed_out}, 32'h1);
        reg_write(CFG_OFFSET, 32'h00C);
        repeat (12) @(negedge sys_clk_i);
        check({31'h0, delayed_out}, 32'h0);
        // pad data rising passes the synchroniser and tap zero
        @(posedge sys_clk_i);
        pad_in <= 1'b1;
        repeat (12) @(negedge sys_clk_i);
        check({31'h0, delayed_out}, 32'h1);
        // cascade: master passes the line on, middle takes the neighbour, end stops the chain
        reg_write(CFG_OFFSET, 32'h04C);
        fabric_tap_driver_inst.load(9'h000);
        repeat (4) @(negedge sys_clk_i);
        check({31'h0, chain_out}, 32'h1);
        reg_write(CFG_OFFSET, 32'h08C);
        repeat (4) @(negedge sys_clk_i);
        check({31'h0, delayed_out}, 32'h0);
        @(posedge sys_clk_i);
        chain_in <= 1'b1;
        repeat (4) @(negedge sys_clk_i);
        check({31'h0, delayed_out}, 32'h1);
        reg_write(CFG_OFFSET, 32'h0CC);
        repeat (4) @(negedge sys_clk_i);
        check({31'h0, chain_out}, 32'h0);
        // manual update: first load stages, second load with step applies
        reg_write(CFG_OFFSET, 32'h02C);
        fabric_tap_driver_inst.load(9'h0AA);
        @(negedge sys_clk_i);
        check({23'h0, tap_out}, 32'h0);
        reg_read(STATUS_OFFSET, rd);
        check(rd, 32'hC00);
        fabric_tap_driver_inst.apply();
        @(negedge sys_clk_i);
        check({23'h0, tap_out}, 32'h0AA);
        // sync update: steady data lets no step through
        reg_write(CFG_OFFSET, 32'h01C);
        fabric_tap_driver_inst.step(1'b1, 3, 1'b0);
        @(negedge sys_clk_i);
        check({23'h0, tap_out}, 32'h0AA);
        // system reset in mid-run clears configuration
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        @(posedge sys_clk_i);
        reset_i <= 1'b0;
        reg_read(CFG_OFFSET, rd);
        check(rd, 32'h0);
        check({23'h0, tap_out}, 32'(ALIGN));
        @(negedge sys_clk_i);
        check(reg_rdata, 32'h0);
        stop_test();
    end
endmodule // tb
